// ===== hdl/gauge_ctrl_pkg.sv
package gauge_ctrl_pkg;

  // =====================================================
  // timing
  localparam int unsigned CLOCK_HZ = 100_000_000;
  localparam int unsigned DEBOUNCE_MS = 50;
  localparam int unsigned DEGAS_DELAY_S = 5;
  // least times: whole cycles, exact at this rate
  localparam int unsigned DEBOUNCE_CYCLES = (CLOCK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned DEGAS_DELAY_CYCLES = CLOCK_HZ * DEGAS_DELAY_S;

  // =====================================================
  // gauge indices and sizes
  localparam int GAUGES = 2;
  localparam int ION_GAUGE_ONE = 0;
  localparam int ION_GAUGE_TWO = 1;
  localparam int REMOTE_INPUTS = 4;

  // =====================================================
  // emission current, tenths of a milliampere
  localparam logic [7:0] EMISSION_LIMIT_TENTHS = 8'h28;

  // =====================================================
  // reset values
  localparam logic RESET_ON = 1'b0;
  localparam logic RESET_LOCK = 1'b1;
  localparam logic RESET_LEVEL = 1'b0;
  localparam logic [31:0] RESET_COUNT = 32'h0000_0000;

endpackage

// ===== hdl/remote_input_filter.sv
`timescale 1ns/100ps

module remote_input_filter
  import gauge_ctrl_pkg::*;
#(
  parameter int unsigned LIMIT = DEBOUNCE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pin_n,
  output logic o_level,
  output logic o_fall
);

  // =====================================================
  // state
  typedef struct packed {
    logic meta;
    logic sync;
    logic level;
    logic fall;
    logic [31:0] count;
  } filter_state_type;

  filter_state_type state_q;
  filter_state_type state_d;

  always_comb begin
    state_d = state_q;
    state_d.fall = 1'b0;
    state_d.meta = i_pin_n;
    state_d.sync = state_q.meta;
    if (state_q.sync == state_q.level) begin
      state_d.count = RESET_COUNT;
    end else if (state_q.count >= LIMIT) begin
      // one more stable sample than the limit: strictly longer
      state_d.level = state_q.sync;
      state_d.fall = ~state_q.sync;
      state_d.count = RESET_COUNT;
    end else begin
      state_d.count = state_q.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= '{meta: RESET_LEVEL, sync: RESET_LEVEL, level: RESET_LEVEL,
                   fall: 1'b0, count: RESET_COUNT};
    end else begin
      state_q <= state_d;
    end
  end

  assign o_level = state_q.level;
  assign o_fall = state_q.fall;

endmodule // remote_input_filter

// ===== hdl/remote_gauge_control.sv
`timescale 1ns/100ps

module remote_gauge_control
  import gauge_ctrl_pkg::*;
#(
  parameter int unsigned DEBOUNCE_LIMIT = DEBOUNCE_CYCLES,
  parameter int unsigned DEGAS_DELAY = DEGAS_DELAY_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  // remote_control_connector pins, active low, asynchronous
  input wire logic [1:0] i_remote_gauge_n,
  input wire logic [1:0] i_remote_degas_n,
  // front panel key pulses, one cycle, same clock
  input wire logic [1:0] i_key_gauge,
  input wire logic [1:0] i_key_degas,
  input wire logic [1:0] i_key_source_select,
  input wire logic i_key_keyboard,
  input wire logic i_emission_current_key,
  input wire logic i_key_other_function,
  // measurement side, same clock
  input wire logic [1:0] i_below_degas_limit,
  input wire logic [1:0] i_gauge_fault,
  input wire logic [3:0] i_pressure_band,
  input wire logic i_single_electrometer,
  output logic [1:0] o_gauge_on,
  output logic [1:0] o_degas_on,
  output logic [1:0] o_status_relay,
  output logic [1:0] o_display_thermal,
  output logic [1:0] o_ion_indicator,
  output logic [1:0] o_thermal_indicator,
  output logic [1:0] o_display_blank,
  output logic o_keypad_mode,
  output logic o_emission_display,
  output logic [7:0] o_emission_one_tenths,
  output logic [7:0] o_emission_two_tenths
);

  // =====================================================
  // remote input filters: [1:0] gauge, [3:2] degas
  logic [REMOTE_INPUTS-1:0] pins_n;
  logic [REMOTE_INPUTS-1:0] level;
  logic [REMOTE_INPUTS-1:0] fall;

  assign pins_n = {i_remote_degas_n, i_remote_gauge_n};

  genvar g;
  generate
    for (g = 0; g < REMOTE_INPUTS; g++) begin : gen_filter
      remote_input_filter #(
        .LIMIT(DEBOUNCE_LIMIT)
      ) u_filter (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin_n(pins_n[g]),
        .o_level(level[g]),
        .o_fall(fall[g])
      );
    end
  endgenerate

  // =====================================================
  // state
  typedef struct packed {
    logic [1:0] gauge_on;
    logic [1:0] degas_on;
    logic [REMOTE_INPUTS-1:0] lock;
    logic [1:0][31:0] on_time;
    logic [1:0] thermal_sel;
    logic keypad;
    logic emission_disp;
    logic [1:0] relay;
    logic [1:0] disp_thermal;
    logic [1:0] ion_led;
    logic [1:0] thermal_led;
    logic [1:0] blank;
    logic [1:0][7:0] emission;
  } ctrl_state_type;

  ctrl_state_type state_q;
  ctrl_state_type state_d;

  // =====================================================
  // next state
  always_comb begin
    logic [1:0] gauge_req;
    logic [1:0] degas_req;
    logic [1:0] gauge_ok;
    logic [1:0] degas_ok;
    logic [1:0] remote_degas_ok;
    logic [1:0] band;
    gauge_req = 2'h0;
    degas_req = 2'h0;
    gauge_ok = 2'h0;
    degas_ok = 2'h0;
    remote_degas_ok = 2'h0;
    band = 2'h0;
    state_d = state_q;

    for (int i = 0; i < GAUGES; i++) begin
      // permission sampled in the cycle the filtered edge arrives
      gauge_ok[i] = 1'b1;
      if (i == ION_GAUGE_TWO && i_single_electrometer && !state_q.gauge_on[ION_GAUGE_TWO] &&
          state_q.gauge_on[ION_GAUGE_ONE]) begin
        gauge_ok[i] = 1'b0;
      end
      // degas may start only while the other gauge is not degassing
      degas_ok[i] = state_q.degas_on[i] ||
                    (state_q.gauge_on[i] && i_below_degas_limit[i] &&
                     !state_q.degas_on[1-i]);
      remote_degas_ok[i] = degas_ok[i] && (state_q.degas_on[i] ||
                           state_q.on_time[i] >= DEGAS_DELAY);

      // low level only, edge not yet spent
      if (fall[i] && !state_q.lock[i] && gauge_ok[i]) begin
        gauge_req[i] = 1'b1;
        state_d.lock[i] = 1'b1;
      end
      if (fall[i+2] && !state_q.lock[i+2] && remote_degas_ok[i]) begin
        degas_req[i] = 1'b1;
        state_d.lock[i+2] = 1'b1;
      end
      // same-cycle key and remote count as one press
      if (i_key_gauge[i] && gauge_ok[i]) begin
        gauge_req[i] = 1'b1;
      end
      if (i_key_degas[i] && degas_ok[i]) begin
        degas_req[i] = 1'b1;
      end
    end

    // lockout released once a settled high is seen
    for (int k = 0; k < REMOTE_INPUTS; k++) begin
      if (level[k]) begin
        state_d.lock[k] = 1'b0;
      end
    end

    for (int i = 0; i < GAUGES; i++) begin
      if (gauge_req[i]) begin
        state_d.gauge_on[i] = ~state_q.gauge_on[i];
      end
      if (i_gauge_fault[i]) begin
        state_d.gauge_on[i] = 1'b0;
      end
      if (degas_req[i]) begin
        state_d.degas_on[i] = ~state_q.degas_on[i];
      end
      // degas cannot outlive its gauge
      if (!state_d.gauge_on[i]) begin
        state_d.degas_on[i] = 1'b0;
      end

      // on time since switch on, saturates at the delay
      if (!state_d.gauge_on[i] || !state_q.gauge_on[i]) begin
        state_d.on_time[i] = RESET_COUNT;
      end else if (state_q.on_time[i] < DEGAS_DELAY) begin
        state_d.on_time[i] = state_q.on_time[i] + 32'h0000_0001;
      end

      if (i_key_source_select[i]) begin
        state_d.thermal_sel[i] = ~state_q.thermal_sel[i];
      end
    end

    // keypad and emission display
    if (i_key_keyboard) begin
      state_d.keypad = ~state_q.keypad;
      state_d.emission_disp = 1'b0;
    end else if (state_q.keypad && i_emission_current_key) begin
      state_d.emission_disp = 1'b1;
    end else if (state_q.keypad && i_key_other_function) begin
      state_d.emission_disp = 1'b0;
    end

    // registered views, derived from the next state
    for (int i = 0; i < GAUGES; i++) begin
      band = i_pressure_band[2*i +: 2];
      state_d.relay[i] = state_d.gauge_on[i];
      // an off ion gauge always falls back to the thermal reading
      state_d.disp_thermal[i] = state_d.thermal_sel[i] || !state_d.gauge_on[i];
      state_d.ion_led[i] = !state_d.disp_thermal[i];
      state_d.thermal_led[i] = state_d.disp_thermal[i];
      state_d.blank[i] = state_d.keypad && !state_d.emission_disp;
      // higher pressure bands halve the current below the limit
      state_d.emission[i] = state_d.gauge_on[i] ?
                            (EMISSION_LIMIT_TENTHS >> band) : 8'h00;
    end
  end

  // =====================================================
  // registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= '0;
      state_q.lock <= {REMOTE_INPUTS{RESET_LOCK}};
      state_q.gauge_on <= {GAUGES{RESET_ON}};
      state_q.degas_on <= {GAUGES{RESET_ON}};
      state_q.disp_thermal <= 2'h3;
      state_q.thermal_led <= 2'h3;
    end else begin
      state_q <= state_d;
    end
  end

  // =====================================================
  // outputs, all straight from flip-flops
  assign o_gauge_on = state_q.gauge_on;
  assign o_degas_on = state_q.degas_on;
  assign o_status_relay = state_q.relay;
  assign o_display_thermal = state_q.disp_thermal;
  assign o_ion_indicator = state_q.ion_led;
  assign o_thermal_indicator = state_q.thermal_led;
  assign o_display_blank = state_q.blank;
  assign o_keypad_mode = state_q.keypad;
  assign o_emission_display = state_q.emission_disp;
  assign o_emission_one_tenths = state_q.emission[ION_GAUGE_ONE];
  assign o_emission_two_tenths = state_q.emission[ION_GAUGE_TWO];

endmodule // remote_gauge_control

// ===== bench/gauge_ctrl_monitor.sv
`timescale 1ns/100ps
module gauge_ctrl_check
  import gauge_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [1:0] i_key_gauge,
  input wire logic [1:0] i_below_degas_limit,
  input wire logic i_single_electrometer,
  input wire logic i_key_keyboard,
  input wire logic [1:0] o_gauge_on,
  input wire logic [1:0] o_degas_on,
  input wire logic [1:0] o_status_relay,
  input wire logic [1:0] o_display_thermal,
  input wire logic o_keypad_mode,
  input wire logic [7:0] o_emission_one_tenths
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ====================
  // checks
  a_relay_follows: assert property (o_status_relay == o_gauge_on)
    else $error("relay differs from gauge state");
  a_reset_all_off: assert property ($fell(i_reset) |-> (o_gauge_on | o_degas_on) == 2'h0)
    else $error("state not off after reset");
  a_degas_needs_on: assert property ((o_degas_on & ~o_gauge_on) == 2'h0)
    else $error("degas without gauge");
  a_degas_one_only: assert property (o_degas_on != 2'h3)
    else $error("both gauges degassing");
  a_degas_needs_low: assert property (!o_degas_on[0] && !i_below_degas_limit[0] |=>
    !o_degas_on[0]) else $error("degas started at high pressure");
  a_single_blocks_two: assert property (i_single_electrometer && o_gauge_on == 2'h1 |=>
    !o_gauge_on[1]) else $error("gauge two on beside gauge one");
  a_key_turns_off: assert property (i_key_gauge[0] && o_gauge_on[0] |=> !o_gauge_on[0])
    else $error("key did not switch gauge off");
  a_keypad_toggles: assert property (i_key_keyboard |=> o_keypad_mode != $past(o_keypad_mode))
    else $error("keyboard key did not toggle keypad");
  // display source is registered from the same next state as the gauge, no lag
  a_thermal_shown: assert property (!o_gauge_on[0] && !o_keypad_mode |->
    o_display_thermal[0]) else $error("thermal not shown");
  a_emission_off: assert property (!o_gauge_on[0] |->
    o_emission_one_tenths == 8'h00) else $error("emission while off");
endmodule // gauge_ctrl_check

bind remote_gauge_control gauge_ctrl_check u_check (.i_clk(i_clk), .i_reset(i_reset),
  .i_key_gauge(i_key_gauge), .i_below_degas_limit(i_below_degas_limit),
  .i_single_electrometer(i_single_electrometer), .i_key_keyboard(i_key_keyboard),
  .o_gauge_on(o_gauge_on), .o_degas_on(o_degas_on), .o_status_relay(o_status_relay),
  .o_display_thermal(o_display_thermal), .o_keypad_mode(o_keypad_mode),
  .o_emission_one_tenths(o_emission_one_tenths));

// ===== bench/remote_ctrl_model.sv
`timescale 1ns/100ps
module remote_ctrl_model #(parameter int HOLD = 24) (
  input wire logic i_clk,
  output logic [1:0] o_gauge_n,
  output logic [1:0] o_degas_n
);
  // ====================
  // released lines rest at the pull-up level
  initial begin
    o_gauge_n = 2'h3;
    o_degas_n = 2'h3;
  end
  // short n only where a glitch is wanted
  task automatic press(input bit degas, input int g, input int n);
    @(negedge i_clk);
    if (degas) o_degas_n[g] = 1'b0;
    else o_gauge_n[g] = 1'b0;
    repeat (n) @(negedge i_clk);
    o_gauge_n = 2'h3;
    o_degas_n = 2'h3;
    repeat (HOLD) @(negedge i_clk);
  endtask
endmodule // remote_ctrl_model

// ===== bench/remote_gauge_control_tb.sv
`timescale 1ns/100ps
module remote_gauge_control_tb;
  import gauge_ctrl_pkg::*;
  logic i_clk = 1'b0, i_reset = 1'b1, single = 1'b0;
  logic [1:0] kg = 2'h0, kd = 2'h0, ks = 2'h0, below = 2'h0, flt = 2'h0, rg_n, rd_n;
  logic [2:0] kk = 3'h0;
  logic [3:0] band = 4'h0;
  logic [1:0] gon, don, rly, thm, ion, thi, blk;
  logic kp, emd;
  logic [7:0] em1, em2;
  bit [1:0] m_on, m_dg, m_sel;
  bit m_kp, m_em;
  logic [31:0] seed = 32'ha0c0;
  int n_fail = 0, checks_done = 0;
  always #5 i_clk = ~i_clk;
  remote_ctrl_model remote (.i_clk(i_clk), .o_gauge_n(rg_n), .o_degas_n(rd_n));
  remote_gauge_control #(.DEBOUNCE_LIMIT(8), .DEGAS_DELAY(20)) dut (.i_clk(i_clk),
    .i_reset(i_reset), .i_remote_gauge_n(rg_n), .i_remote_degas_n(rd_n), .i_key_gauge(kg),
    .i_key_degas(kd), .i_key_source_select(ks), .i_key_keyboard(kk[0]),
    .i_emission_current_key(kk[1]), .i_key_other_function(kk[2]),
    .i_below_degas_limit(below), .i_gauge_fault(flt), .i_pressure_band(band),
    .i_single_electrometer(single), .o_gauge_on(gon), .o_degas_on(don), .o_status_relay(rly),
    .o_display_thermal(thm), .o_ion_indicator(ion), .o_thermal_indicator(thi),
    .o_display_blank(blk), .o_keypad_mode(kp), .o_emission_display(emd),
    .o_emission_one_tenths(em1), .o_emission_two_tenths(em2));
  // ====================
  // model and checks
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function void m_gauge(int g);
    if (m_on[g]) begin
      m_on[g] = 0;
      m_dg[g] = 0;
    end else if (!(single && g == 1 && m_on[0])) m_on[g] = 1;
  endfunction
  function void m_degas(int g, bit early);
    if (m_dg[g]) m_dg[g] = 0;
    else if (m_on[g] && below[g] && !m_dg[1-g] && !early) m_dg[g] = 1;
  endfunction
  task done_test(input string s);
    for (int i = 0; i < 2; i++) begin
      chk(gon[i], m_on[i]);
      chk(rly[i], m_on[i]);
      chk(don[i], m_dg[i]);
      chk(i ? em2 : em1, m_on[i] ? EMISSION_LIMIT_TENTHS >> band[2*i+:2] : 8'h00);
      if (!m_kp) chk(thm[i], m_sel[i] | !m_on[i]);
      if (!m_kp) chk({ion[i], thi[i]}, {!(m_sel[i] | !m_on[i]), m_sel[i] | !m_on[i]});
    end
    chk({kp, emd, blk}, {m_kp, m_em, {2{m_kp & !m_em}}});
    $display("test %s done", s);
  endtask
  task automatic pulse(ref logic [1:0] v, input int i);
    @(negedge i_clk);
    v[i] = 1'b1;
    @(negedge i_clk);
    v[i] = 1'b0;
    @(negedge i_clk);
  endtask
  task key3(input int i);
    @(negedge i_clk);
    kk[i] = 1'b1;
    @(negedge i_clk);
    kk[i] = 1'b0;
    @(negedge i_clk);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // long enough for every scenario, short enough to catch a hang
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
  // ====================
  // scenarios
  initial begin
    band = 4'(xs());
    repeat (6) @(posedge i_clk);
    @(negedge i_clk) i_reset = 1'b0;
    done_test("reset");
    repeat (30) @(negedge i_clk);
    pulse(kg, 0); m_gauge(0); done_test("key on");
    remote.press(0, 0, 24); m_gauge(0); done_test("remote off");
    remote.press(0, 0, 3); done_test("glitch");
    remote.press(0, 0, 90); m_gauge(0); done_test("held low");
    single = 1'b1;
    remote.press(0, 1, 24); m_gauge(1); done_test("refused two");
    pulse(kg, 0); m_gauge(0); pulse(kg, 1); m_gauge(1); pulse(kg, 1); m_gauge(1);
    done_test("single");
    single = 1'b0;
    below = 2'h3;
    pulse(kg, 0); m_gauge(0);
    remote.press(1, 0, 24); m_degas(0, 1); done_test("early degas");
    remote.press(1, 0, 24); m_degas(0, 0); done_test("remote degas");
    pulse(kg, 1); m_gauge(1); pulse(kd, 1); m_degas(1, 0); done_test("one degas");
    remote.press(1, 0, 24); m_degas(0, 0); below[1] = 1'b0;
    pulse(kd, 1); m_degas(1, 0); done_test("high pressure");
    below[1] = 1'b1;
    pulse(kd, 1); m_degas(1, 0); pulse(kg, 1); m_gauge(1); done_test("gauge off");
    for (int i = 0; i < 2; i++) begin
      pulse(ks, 0); m_sel[0] = !m_sel[0]; done_test("select");
    end
    key3(0); m_kp = 1; key3(1); m_em = 1; done_test("emission");
    key3(2); m_em = 0; key3(1); m_em = 1; key3(0); m_kp = 0; m_em = 0;
    done_test("keypad");
    for (int i = 0; i < 4; i++) begin
      @(negedge i_clk) band = 4'(xs());
      repeat (3) @(negedge i_clk);
      done_test("band");
    end
    // a fault forces gauge one off, its relay must drop with it
    pulse(flt, 0); m_on[0] = 0; m_dg[0] = 0; done_test("fault");
    finish_test;
  end
endmodule // remote_gauge_control_tb
